//--- pvs_cfg.svh
// constants for the input threshold, phase group and over-voltage action registers
// assumes a pmbus slave front end decodes command codes and byte counts upstream
`ifndef PVS_CFG_SVH
`define PVS_CFG_SVH
`define PVS_CMD_START      8'h35
`define PVS_CMD_STOP       8'h36
`define PVS_CMD_PHASE      8'h37
`define PVS_CMD_OVACT      8'h41
`define PVS_START_RST      16'hf80c
`define PVS_STOP_RST       16'hf80c
`define PVS_PHASE_RST      16'h0000
`define PVS_OVACT_RST      8'h40
`define PVS_THR_HI         11'h7c0
`define PVS_START_MIN      5'h06
`define PVS_START_MAX      5'h15
`define PVS_STOP_MIN       5'h05
`define PVS_STOP_MAX       5'h14
`define PVS_PH_MASTER      16'h0100
`define PVS_PH_SLV_IN      16'h0120
`define PVS_PH_SLV_OUT     16'h0121
`define PVS_CLK_MHZ        50
`define PVS_DLY0_NS        6250
`define PVS_DLY1_NS        7500
`define PVS_DLY2_NS        8750
`define PVS_DLY3_NS        10000
`define PVS_HICCUP_MS      1000
`define PVS_HICCUP_CYC     (`PVS_HICCUP_MS * 1000 * `PVS_CLK_MHZ)
`define PVS_NS2CYC(ns)     (((ns) * `PVS_CLK_MHZ) / 1000)
`endif

//--- pvs_pkg.sv
// types shared by the configuration block and its users
// assumes pvs_cfg.svh is compiled alongside
package pvs_pkg;
	typedef enum logic [3:0] {
		PVS_RUN   = 4'b0001,
		PVS_DELAY = 4'b0010,
		PVS_OFF   = 4'b0100,
		PVS_HICC  = 4'b1000
	} pvs_ov_e;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] cmd;
		logic [15:0] data;
	} pvs_req_s;
	typedef struct packed {
		logic [1:0] action;
		logic [2:0] retry;
		logic [2:0] delay;
	} pvs_ovact_s;
endpackage

//--- pvs_config.sv
// over-voltage response, input thresholds and phase grouping registers
// assumes one-cycle command strobes from the pmbus slave on core_clk; analog inputs are raw
`timescale 1ns/100ps
`include "pvs_cfg.svh"
module pvs_config #(
	parameter int unsigned HICCUP_CYC = `PVS_HICCUP_CYC
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire pvs_pkg::pvs_req_s  req,
	output logic [15:0]             rd_data,
	output logic                    rd_valid,
	output logic                    invalid_data,
	input  wire logic               clear_faults,
	input  wire logic               save_all,
	output logic                    nvm_wr,
	output logic [55:0]             nvm_data,
	input  wire logic               bias_ok_pin,
	input  wire logic               vin_above_start_pin,
	output logic                    input_undervolt_lockout,
	input  wire logic               ov_detect_pin,
	input  wire logic               zero_warn_pin,
	input  wire logic               lowside_on_opt,
	output logic                    status_byte_ov,
	output logic                    status_word_vout,
	output logic                    output_volt_flags_ov,
	output logic                    host_alert_n,
	output logic                    conv_enable,
	output logic                    hs_on_allow,
	output logic                    ls_force_on,
	input  wire logic               int_clk,
	input  wire logic               sync_in_pin,
	output logic                    sync_out,
	output logic                    sync_oe,
	output logic                    sw_clk
);
	// ----------------------------------------------------------------
	// response delay counts
	// ----------------------------------------------------------------
	localparam logic [9:0] DLY0 = 10'(`PVS_NS2CYC(`PVS_DLY0_NS));
	localparam logic [9:0] DLY1 = 10'(`PVS_NS2CYC(`PVS_DLY1_NS));
	localparam logic [9:0] DLY2 = 10'(`PVS_NS2CYC(`PVS_DLY2_NS));
	localparam logic [9:0] DLY3 = 10'(`PVS_NS2CYC(`PVS_DLY3_NS));

	logic [15:0]           start_reg;
	logic [15:0]           stop_reg;
	logic [15:0]           phase_reg;
	pvs_pkg::pvs_ovact_s   ovact_reg;
	logic [1:0]            bias_sy, vin_sy, ov_sy, zw_sy, int_sy;
	logic [2:0]            syn_sy;
	logic                  bias_q, vin_q, ov_q, zw_q, syn_q;
	pvs_pkg::pvs_ov_e      ov_st;
	logic [31:0]           cnt_reg;
	logic [9:0]            dly_cyc;
	logic [4:0]            wr_mant;
	logic                  wr_start_ok, wr_stop_ok, wr_phase_ok, wr_ovact_ok;
	logic                  wr_any, wr_bad;
	logic [7:0]            edge_cnt;
	logic                  sync_live;
	logic                  int_q;

	// ----------------------------------------------------------------
	// pin synchronisers: first stage feeds only the second
	// ----------------------------------------------------------------
	// the internal oscillator runs free of core_clk, so it is treated like a pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bias_sy <= 2'h0;
			vin_sy  <= 2'h0;
			ov_sy   <= 2'h0;
			zw_sy   <= 2'h0;
			int_sy  <= 2'h0;
			syn_sy  <= 3'h0;
		end else if (clk_en) begin
			bias_sy <= {bias_sy[0], bias_ok_pin};
			vin_sy  <= {vin_sy[0], vin_above_start_pin};
			ov_sy   <= {ov_sy[0], ov_detect_pin};
			zw_sy   <= {zw_sy[0], zero_warn_pin};
			int_sy  <= {int_sy[0], int_clk};
			syn_sy  <= {syn_sy[1:0], sync_in_pin};
		end
	end
	assign bias_q = bias_sy[1];
	assign vin_q  = vin_sy[1];
	assign ov_q   = ov_sy[1];
	assign zw_q   = zw_sy[1];
	assign syn_q  = syn_sy[1];

	// ----------------------------------------------------------------
	// write checks
	// ----------------------------------------------------------------
	// only the low five mantissa bits matter; upper bits must match the fixed pattern
	assign wr_mant = req.data[4:0];
	always_comb begin
		wr_start_ok = (req.data[15:5] == `PVS_THR_HI)
			&& (wr_mant >= `PVS_START_MIN) && (wr_mant <= `PVS_START_MAX)
			&& (wr_mant > stop_reg[4:0]);
		wr_stop_ok = (req.data[15:5] == `PVS_THR_HI)
			&& (wr_mant >= `PVS_STOP_MIN) && (wr_mant <= `PVS_STOP_MAX)
			&& (wr_mant <= start_reg[4:0]);
		wr_phase_ok = (req.data == `PVS_PHASE_RST) || (req.data == `PVS_PH_MASTER)
			|| (req.data == `PVS_PH_SLV_IN) || (req.data == `PVS_PH_SLV_OUT);
		wr_ovact_ok = (req.data[7] == 1'b0)
			&& ((req.data[5:3] == 3'h0) || (req.data[5:3] == 3'h7));
	end
	assign wr_any = req.valid && req.write && clk_en;
	always_comb begin
		wr_bad = 1'b0;
		if (wr_any) begin
			unique case (req.cmd)
				`PVS_CMD_START: wr_bad = !wr_start_ok;
				`PVS_CMD_STOP:  wr_bad = !wr_stop_ok;
				`PVS_CMD_PHASE: wr_bad = !wr_phase_ok;
				`PVS_CMD_OVACT: wr_bad = !wr_ovact_ok;
				default:        wr_bad = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers; a rejected write keeps the old value
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_reg <= `PVS_START_RST;
			stop_reg  <= `PVS_STOP_RST;
			phase_reg <= `PVS_PHASE_RST;
			ovact_reg <= `PVS_OVACT_RST;
		end else if (wr_any && !wr_bad) begin
			unique case (req.cmd)
				`PVS_CMD_START: start_reg <= {`PVS_THR_HI, wr_mant};
				`PVS_CMD_STOP:  stop_reg  <= {`PVS_THR_HI, wr_mant};
				`PVS_CMD_PHASE: phase_reg <= req.data;
				`PVS_CMD_OVACT: ovact_reg <= req.data[7:0];
				default:        ;
			endcase
		end
	end

	// read-back and invalid-data flag; a new rejection wins over a clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data      <= 16'h0000;
			rd_valid     <= 1'b0;
			invalid_data <= 1'b0;
		end else if (clk_en) begin
			rd_valid <= req.valid && !req.write;
			unique case (req.cmd)
				`PVS_CMD_START: rd_data <= start_reg;
				`PVS_CMD_STOP:  rd_data <= stop_reg;
				`PVS_CMD_PHASE: rd_data <= phase_reg;
				`PVS_CMD_OVACT: rd_data <= {8'h00, ovact_reg};
				default:        rd_data <= 16'h0000;
			endcase
			if (wr_bad)
				invalid_data <= 1'b1;
			else if (clear_faults)
				invalid_data <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// nonvolatile save
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_wr   <= 1'b0;
			nvm_data <= 56'h0;
		end else if (clk_en) begin
			nvm_wr <= save_all;
			if (save_all)
				nvm_data <= {start_reg, stop_reg, phase_reg, ovact_reg};
		end
	end

	// ----------------------------------------------------------------
	// input lockout fault: sticky until cleared, event wins
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			input_undervolt_lockout <= 1'b0;
		else if (clk_en) begin
			if (bias_q && !vin_q)
				input_undervolt_lockout <= 1'b1;
			else if (clear_faults)
				input_undervolt_lockout <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// over-voltage status flags and alert
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_byte_ov       <= 1'b0;
			status_word_vout     <= 1'b0;
			output_volt_flags_ov <= 1'b0;
			host_alert_n         <= 1'b1;
		end else if (clk_en) begin
			if (ov_q) begin
				status_byte_ov       <= 1'b1;
				status_word_vout     <= 1'b1;
				output_volt_flags_ov <= 1'b1;
				host_alert_n         <= 1'b0;
			end else if (clear_faults) begin
				status_byte_ov       <= 1'b0;
				status_word_vout     <= 1'b0;
				output_volt_flags_ov <= 1'b0;
				host_alert_n         <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// over-voltage response sequencer
	// ----------------------------------------------------------------
	always_comb begin
		unique case (ovact_reg.delay[1:0])
			2'h0:    dly_cyc = DLY0;
			2'h1:    dly_cyc = DLY1;
			2'h2:    dly_cyc = DLY2;
			default: dly_cyc = DLY3;
		endcase
	end

	// hiccup restarts repeat while the fault persists; the state also gates conversion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_st   <= pvs_pkg::PVS_RUN;
			cnt_reg <= 32'h0;
		end else if (clk_en) begin
			unique case (ov_st)
				pvs_pkg::PVS_RUN: begin
					cnt_reg <= 32'h0;
					if (ov_q && ovact_reg.action == 2'h1)
						ov_st <= pvs_pkg::PVS_DELAY;
				end
				pvs_pkg::PVS_DELAY: begin
					cnt_reg <= cnt_reg + 32'h1;
					if (!ov_q)
						ov_st <= pvs_pkg::PVS_RUN;
					else if (cnt_reg + 32'h1 >= {22'h0, dly_cyc}) begin
						cnt_reg <= 32'h0;
						ov_st   <= (ovact_reg.retry == 3'h7) ? pvs_pkg::PVS_HICC
							: pvs_pkg::PVS_OFF;
					end
				end
				pvs_pkg::PVS_OFF: begin
					if (clear_faults)
						ov_st <= pvs_pkg::PVS_RUN;
				end
				pvs_pkg::PVS_HICC: begin
					cnt_reg <= cnt_reg + 32'h1;
					if (clear_faults)
						ov_st <= pvs_pkg::PVS_RUN;
					else if (cnt_reg + 32'h1 >= HICCUP_CYC) begin
						cnt_reg <= 32'h0;
						ov_st   <= pvs_pkg::PVS_RUN;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// power switch control
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_enable <= 1'b0;
			hs_on_allow <= 1'b0;
			ls_force_on <= 1'b0;
		end else if (clk_en) begin
			conv_enable <= (ov_st == pvs_pkg::PVS_RUN || ov_st == pvs_pkg::PVS_DELAY)
				&& !input_undervolt_lockout;
			hs_on_allow <= !zw_q;
			ls_force_on <= zw_q && lowside_on_opt;
		end
	end

	// ----------------------------------------------------------------
	// sync pin: presence watchdog and clock selection
	// ----------------------------------------------------------------
	// sync counted live while edges keep arriving; 256 cycles without one drops it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt  <= 8'h00;
			sync_live <= 1'b0;
		end else if (clk_en) begin
			if (syn_q != syn_sy[2]) begin
				edge_cnt  <= 8'h00;
				sync_live <= 1'b1;
			end else if (edge_cnt == 8'hff)
				sync_live <= 1'b0;
			else
				edge_cnt <= edge_cnt + 8'h01;
		end
	end

	// switching clock reaches the selector two flops late, like the sync pin
	assign int_q = int_sy[1];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_out <= 1'b0;
			sync_oe  <= 1'b0;
			sw_clk   <= 1'b0;
		end else if (clk_en) begin
			sync_oe  <= (phase_reg == `PVS_PH_MASTER);
			sync_out <= (phase_reg == `PVS_PH_MASTER) && int_q;
			if (phase_reg == `PVS_PH_SLV_IN && sync_live)
				sw_clk <= syn_q;
			else if (phase_reg == `PVS_PH_SLV_OUT && sync_live)
				sw_clk <= !syn_q;
			else
				sw_clk <= int_q;
		end
	end
endmodule

//--- pvs_config_monitor.sv
// port assertions for the configuration block
// assumes it is bound onto every pvs_config instance
`timescale 1ns/100ps
module pvs_monitor #(
	parameter int unsigned HICCUP_CYC = 100
) (
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic              clk_en,
	input wire pvs_pkg::pvs_req_s req,
	input wire logic              rd_valid,
	input wire logic              invalid_data,
	input wire logic              clear_faults,
	input wire logic              save_all,
	input wire logic              nvm_wr,
	input wire logic              ov_detect_pin,
	input wire logic              status_byte_ov,
	input wire logic              status_word_vout,
	input wire logic              output_volt_flags_ov,
	input wire logic              host_alert_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// command checks
	// ----------------------------------------
	// an accepted write strobe; clk_en low means the edge is not taken
	wire wr_take = req.valid && req.write && clk_en;
	AST_READ_ANSWER: assert property (req.valid && !req.write && clk_en |=> rd_valid)
		else $error("read not answered");
	AST_START_RANGE: assert property (wr_take && req.cmd == 8'h35
		&& (req.data < 16'hf806 || req.data > 16'hf815) |=> invalid_data)
		else $error("bad start code accepted");
	AST_STOP_RANGE: assert property (wr_take && req.cmd == 8'h36
		&& (req.data < 16'hf805 || req.data > 16'hf814) |=> invalid_data)
		else $error("bad stop code accepted");
	AST_OVACT_CODE: assert property (wr_take && req.cmd == 8'h41
		&& (req.data[7] || !(req.data[5:3] inside {3'h0, 3'h7})) |=> invalid_data)
		else $error("bad action code accepted");
	AST_INVALID_HOLD: assert property (invalid_data && !clear_faults |=> invalid_data)
		else $error("invalid flag dropped");
	// ----------------------------------------
	// fault checks
	// ----------------------------------------
	// two sync flops plus the flag register give three edges of latency
	AST_OV_SET: assert property ((ov_detect_pin && clk_en)[*3] |=> status_byte_ov)
		else $error("ov flag not set");
	AST_OV_FLAGS: assert property (status_byte_ov
		|-> status_word_vout && output_volt_flags_ov && !host_alert_n)
		else $error("ov flags disagree");
	AST_OV_HOLD: assert property (status_byte_ov && !clear_faults |=> status_byte_ov)
		else $error("ov flag dropped");
	AST_SAVE: assert property (save_all && clk_en |=> nvm_wr)
		else $error("save not written");
	cover property (wr_take && req.cmd == 8'h41);
	cover property ($rose(status_byte_ov));
	cover property (nvm_wr);
endmodule
bind pvs_config pvs_monitor #(.HICCUP_CYC(HICCUP_CYC)) mon (
	.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
	.rd_valid(rd_valid), .invalid_data(invalid_data), .clear_faults(clear_faults),
	.save_all(save_all), .nvm_wr(nvm_wr), .ov_detect_pin(ov_detect_pin),
	.status_byte_ov(status_byte_ov), .status_word_vout(status_word_vout),
	.output_volt_flags_ov(output_volt_flags_ov), .host_alert_n(host_alert_n));

//--- pvs_host.sv
// host model issuing configuration commands
// assumes requests are launched on the falling edge of core_clk
`timescale 1ns/100ps
module pvs_host (
	input  wire logic             core_clk,
	input  wire logic [15:0]      rd_data,
	input  wire logic             rd_valid,
	output pvs_pkg::pvs_req_s     req
);
	initial req = '0;
	// one-cycle strobe; data turned over once released so stale values never match
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge core_clk);
		req = '{1'b1, 1'b1, c, d};
		@(negedge core_clk);
		req.valid = 1'b0;
		req.data = ~d;
	endtask
	// bounded wait on the read pulse; no answer returns unknown
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		int n;
		@(negedge core_clk);
		req = '{1'b1, 1'b0, c, ~req.data};
		@(negedge core_clk);
		req.valid = 1'b0;
		for (n = 0; n < 3 && rd_valid !== 1'b1; n++) @(negedge core_clk);
		d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
	endtask
endmodule

//--- pmbus_vin_sync_ov_config_tb_top.sv
// self-checking bench for the configuration block
// assumes pvs_host as command source and pins driven on falling edges
`timescale 1ns/100ps
module pmbus_vin_sync_ov_config_tb_top;
	logic core_clk = 0, rst_n = 0, clk_en = 1, clear_faults = 0, save_all = 0;
	logic bias_ok_pin = 0, vin_above_start_pin = 0, ov_detect_pin = 0;
	logic zero_warn_pin = 0, lowside_on_opt = 0, int_clk = 0, sync_in_pin = 0;
	logic [15:0] rd_data;
	logic [55:0] nvm_data;
	logic rd_valid, invalid_data, nvm_wr, input_undervolt_lockout;
	logic status_byte_ov, status_word_vout;
	logic output_volt_flags_ov, host_alert_n, conv_enable, hs_on_allow, ls_force_on;
	logic sync_out, sync_oe, sw_clk;
	pvs_pkg::pvs_req_s req;
	int num_errors = 0, checks = 0, cyc = 0;
	always #10 core_clk = ~core_clk;
	// internal clock toggles on falling edges only, period of four core cycles
	always #40 int_clk = ~int_clk;
	// int_clk as sampled on the last three rising edges; two sync flops plus the output flop
	logic [2:0] ic_hist = 3'h0;
	always @(posedge core_clk) ic_hist <= {ic_hist[1:0], int_clk};
	pvs_host host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
	pvs_config #(.HICCUP_CYC(100)) uut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.req(req), .rd_data(rd_data), .rd_valid(rd_valid), .invalid_data(invalid_data),
		.clear_faults(clear_faults), .save_all(save_all), .nvm_wr(nvm_wr),
		.nvm_data(nvm_data), .bias_ok_pin(bias_ok_pin),
		.vin_above_start_pin(vin_above_start_pin),
		.input_undervolt_lockout(input_undervolt_lockout),
		.ov_detect_pin(ov_detect_pin), .zero_warn_pin(zero_warn_pin),
		.lowside_on_opt(lowside_on_opt), .status_byte_ov(status_byte_ov),
		.status_word_vout(status_word_vout), .output_volt_flags_ov(output_volt_flags_ov),
		.host_alert_n(host_alert_n), .conv_enable(conv_enable), .hs_on_allow(hs_on_allow),
		.ls_force_on(ls_force_on), .int_clk(int_clk), .sync_in_pin(sync_in_pin),
		.sync_out(sync_out), .sync_oe(sync_oe), .sw_clk(sw_clk));
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [55:0] e, input logic [55:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic cf();
		@(negedge core_clk) clear_faults = 1;
		@(negedge core_clk) clear_faults = 0;
	endtask
	task automatic rc(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		host.rd(c, d);
		chk("readback", e, d);
	endtask
	// write, judge the invalid flag, then clear it after an expected rejection
	task automatic wi(input logic [7:0] c, input logic [15:0] d, input logic bad);
		host.wr(c, d);
		wait_n(1);
		chk("invalid_data", bad, invalid_data);
		if (bad) cf();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		rc(8'h35, 16'hf80c);
		rc(8'h36, 16'hf80c);
		rc(8'h37, 16'h0000);
		rc(8'h41, 16'h0040);
		chk("host_alert_n", 1, host_alert_n);
	endtask
	task automatic t_pins();
		bias_ok_pin = 1;
		wait_n(8);
		chk("input_undervolt_lockout", 1, input_undervolt_lockout);
		vin_above_start_pin = 1;
		zero_warn_pin = 1;
		wait_n(5);
		chk("hs_on_allow", 0, hs_on_allow);
		chk("ls_force_on", 0, ls_force_on);
		lowside_on_opt = 1;
		wait_n(5);
		chk("ls_force_on", 1, ls_force_on);
		zero_warn_pin = 0;
		lowside_on_opt = 0;
		cf();
		chk("input_undervolt_lockout", 0, input_undervolt_lockout);
	endtask
	task automatic t_thresh();
		wi(8'h36, 16'hf805, 0);
		wi(8'h35, 16'hf815, 0);
		rc(8'h35, 16'hf815);
		wi(8'h35, 16'hf816, 1);
		rc(8'h35, 16'hf815);
		wi(8'h35, 16'hf915, 1);
		wi(8'h35, 16'hf805, 1);
		wi(8'h36, 16'hf814, 0);
		wi(8'h35, 16'hf814, 1);
		wi(8'h36, 16'hf815, 1);
		wi(8'h36, 16'hf804, 1);
		wi(8'h36, 16'hf80a, 0);
		wi(8'h35, 16'hf80b, 0);
		wi(8'h36, 16'hf80b, 0);
		wi(8'h36, 16'hf80c, 1);
		rc(8'h36, 16'hf80b);
		wi(8'h35, 16'hf80c, 0);
	endtask
	task automatic t_phase();
		logic [15:0] mode [4] = '{16'h0100, 16'h0120, 16'h0121, 16'h0000};
		foreach (mode[i]) begin
			wi(8'h37, mode[i], 0);
			wait_n(4);
			// one full internal clock period; sync edges from the in-phase mode still hold sync live in the out-of-phase mode
			for (int j = 0; j < 4; j++) begin
				chk("sync_oe", mode[i] == 16'h0100, sync_oe);
				chk("sync_out", mode[i] == 16'h0100 && ic_hist[2], sync_out);
				if (mode[i] != 16'h0121)
					chk("sw_clk", ic_hist[2], sw_clk);
				wait_n(1);
			end
			if (mode[i] inside {16'h0120, 16'h0121}) begin
				sync_in_pin = 1;
				wait_n(6);
				chk("sw_clk", mode[i] == 16'h0120, sw_clk);
				sync_in_pin = 0;
				wait_n(6);
				chk("sw_clk", mode[i] == 16'h0121, sw_clk);
			end
		end
		wi(8'h37, 16'h0200, 1);
		rc(8'h37, 16'h0000);
	endtask
	task automatic t_ovact();
		logic [7:0] c [8] = '{8'h80, 8'hc0, 8'h48, 8'h70, 8'h00, 8'h7f, 8'h47, 8'h40};
		foreach (c[i]) wi(8'h41, {8'h00, c[i]}, i < 4);
		rc(8'h41, 16'h0040);
	endtask
	task automatic t_ov();
		wi(8'h41, 16'h0000, 0);
		ov_detect_pin = 1;
		wait_n(5);
		ov_detect_pin = 0;
		wait_n(10);
		chk("ov flags", 4'b1110, {status_byte_ov, status_word_vout,
			output_volt_flags_ov, host_alert_n});
		chk("conv_enable", 1, conv_enable);
		cf();
		wait_n(4);
		chk("status_byte_ov", 0, status_byte_ov);
		wi(8'h41, 16'h0040, 0);
		ov_detect_pin = 1;
		wait_n(300);
		chk("conv_enable", 1, conv_enable);
		wait_n(30);
		chk("conv_enable", 0, conv_enable);
		ov_detect_pin = 0;
		wait_n(20);
		chk("conv_enable", 0, conv_enable);
		cf();
		wait_n(5);
		chk("conv_enable", 1, conv_enable);
		// delay code 11 is 500 cycles, then a 100-cycle hiccup at this bench's setting
		wi(8'h41, 16'h007b, 0);
		ov_detect_pin = 1;
		wait_n(490);
		chk("conv_enable", 1, conv_enable);
		wait_n(20);
		chk("conv_enable", 0, conv_enable);
		wait_n(100);
		chk("conv_enable", 1, conv_enable);
		ov_detect_pin = 0;
		wi(8'h41, 16'h0040, 0);
		cf();
	endtask
	task automatic t_save();
		// a write made while clk_en is low must not be taken
		@(negedge core_clk) clk_en = 0;
		host.wr(8'h35, 16'hf80d);
		@(negedge core_clk) clk_en = 1;
		rc(8'h35, 16'hf80c);
		@(negedge core_clk) save_all = 1;
		@(negedge core_clk) save_all = 0;
		chk("nvm_wr", 1, nvm_wr);
		chk("nvm_data", {16'hf80c, 16'hf80b, 16'h0000, 8'h40}, nvm_data);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// hang guard; the full run needs under two thousand cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		wait_n(2);
		rst_n = 1;
		t_defaults();
		t_pins();
		t_thresh();
		t_phase();
		t_ovact();
		t_ov();
		t_save();
		end_of_test();
	end
endmodule
